// ===== rtl/gdrv_status_flags.sv
/*
  Global status flag bank of a three-phase gate driver, with its
  serial control slave. Holds reset-seen, overtemperature prewarning and
  overtemperature shutdown flags, cleared by write-one or driver enable
  cycling, and drives the status pin.
  Assumes temperature comparators and driver enable come from outside
  the clock domain; the host keeps its own gate inputs off on shorts.
*/
// Behaviour
// - Writing one clears that flag bit
// - Enable cycle clears all but bits 0,1
// - Any reset sets reset flag, defaults others
// - Reset flag clears only with enable high
// - Prewarning latches at bit 1, no action
// - Shutdown latches at bit 2 on overtemperature
// - Shutdown flag clear ignored while still hot
// - Shutdown flag ORed onto status pin
`timescale 1ns/1ps
module gdrv_status_flags
  import gdrv_status_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // Serial control pins
  input wire logic SCK_I,
  input wire logic CSN_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OEN_O,
  // Driver enable pin and temperature comparators
  input wire logic DRV_EN_I,
  input wire logic OTEMP_WARN_I,
  input wire logic OTEMP_SHUT_I,
  // Status pin, driver shutdown and flag register view
  output logic STATUS_O,
  output logic DRV_SHUTDOWN_O,
  output logic [gdrv_status_pkg::FLAG_WIDTH-1:0] FLAGS_O
);
  import gdrv_status_pkg::*;

  // ==========================================================
  // Serial slave
  gdrv_reg_if bus ();

  gdrv_spi_slave u_spi (
    .clk_i(MCLK_I),
    .rst_n_i(RSTN_I),
    .sck_i(SCK_I),
    .cs_n_i(CSN_I),
    .sdi_i(SDI_I),
    .sdo_o(SDO_O),
    .sdo_oe_n_o(SDO_OEN_O),
    .bus(bus)
  );

  // ==========================================================
  // Synchronisers for enable and temperature levels
  logic [2:0] meta_reg;                     // First stage, read only below
  logic [2:0] sync_reg;                     // Second stage: en, warn, shut
  logic en_q_reg;                           // Delayed enable for edges

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      // One two-stage synchroniser per level input
      always_ff @(posedge MCLK_I or negedge RSTN_I)
      begin
        if (!RSTN_I)
        begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= (gi == 0) ? DRV_EN_I : (gi == 1) ? OTEMP_WARN_I : OTEMP_SHUT_I;
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  wire drv_en = sync_reg[0];
  wire otemp_warn = sync_reg[1];
  wire otemp_shut = sync_reg[2];

  // ==========================================================
  // Driver enable cycle detection
  // Armed only by a seen falling edge, so a pin already high at reset
  // does not fake a cycle when the synchroniser fills.
  logic armed_reg, armed_next;
  logic cycle_reg, cycle_next;              // One-cycle clear pulse

  always_comb
  begin
    armed_next = armed_reg;
    cycle_next = 1'b0;
    if (en_q_reg && !drv_en)
      armed_next = 1'b1;
    else if (!en_q_reg && drv_en && armed_reg)
    begin
      armed_next = 1'b0;
      cycle_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      en_q_reg <= 1'b0;
      armed_reg <= 1'b0;
      cycle_reg <= 1'b0;
    end
    else
    begin
      en_q_reg <= drv_en;
      armed_reg <= armed_next;
      cycle_reg <= cycle_next;
    end
  end

  // ==========================================================
  // Flag bank
  logic [FLAG_WIDTH-1:0] flags_reg, flags_next;
  logic [FLAG_WIDTH-1:0] clr;               // Clear requests per bit
  logic [FLAG_WIDTH-1:0] set;               // Set requests per bit
  logic [FLAG_WIDTH-1:0] wr_ones;           // Write-one bits to this register

  // Clears and sets; set beats clear so no event is lost
  always_comb
  begin
    wr_ones = '0;
    if (bus.wr && bus.addr == ADDR_GLOBAL_STATUS)
      wr_ones = bus.wdata[FLAG_WIDTH-1:0];
    clr = '0;
    clr[BIT_RESET_SEEN] = wr_ones[BIT_RESET_SEEN] & drv_en;
    clr[BIT_OTEMP_WARN] = wr_ones[BIT_OTEMP_WARN];
    // Shutdown flag stays while the die is still above the limit
    clr[BIT_OTEMP_SHUT] = (wr_ones[BIT_OTEMP_SHUT] | cycle_reg) & ~otemp_shut;
    set = '0;
    set[BIT_OTEMP_WARN] = otemp_warn;
    set[BIT_OTEMP_SHUT] = otemp_shut;
    flags_next = (flags_reg & ~clr) | set;
  end

  // Any reset brings the bank back with the reset-seen flag up
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      flags_reg <= FLAGS_RESET;
    else
      flags_reg <= flags_next;
  end

  // ==========================================================
  // Read side and pins
  // Unmapped addresses read as zero
  assign bus.rdata = (bus.addr == ADDR_GLOBAL_STATUS) ?
                     {{(DATA_BITS-FLAG_WIDTH){1'b0}}, flags_reg} : '0;
  // Prewarning is information only: it never reaches the shutdown path
  assign DRV_SHUTDOWN_O = flags_reg[BIT_OTEMP_SHUT];
  assign STATUS_O = flags_reg[BIT_OTEMP_SHUT];
  assign FLAGS_O = flags_reg;

  // ==========================================================
  // Checks
  // Phrased on the registered flags, so they see what a host would read
  // back rather than the transient next-state value.
  AST_CLEAR_ON_ONE: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    bus.wr && bus.addr == ADDR_GLOBAL_STATUS && bus.wdata[BIT_OTEMP_WARN] && !otemp_warn
    |=> !flags_reg[BIT_OTEMP_WARN])
    else $error("prewarning flag not cleared by one");

  AST_ZERO_KEEPS: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    bus.wr && !bus.wdata[BIT_OTEMP_WARN] && !cycle_reg && flags_reg[BIT_OTEMP_WARN]
    |=> flags_reg[BIT_OTEMP_WARN])
    else $error("flag lost on zero write");

  AST_CYCLE_CLEARS: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    cycle_reg && !otemp_shut && !otemp_warn && !bus.wr
    |=> !flags_reg[BIT_OTEMP_SHUT] && flags_reg[BIT_RESET_SEEN] == $past(flags_reg[BIT_RESET_SEEN])
        && flags_reg[BIT_OTEMP_WARN] == $past(flags_reg[BIT_OTEMP_WARN]))
    else $error("enable cycle clear wrong");

  AST_RESET_SEEN: assert property (@(posedge MCLK_I)
    $rose(RSTN_I) |-> flags_reg == FLAGS_RESET)
    else $error("reset value wrong");

  AST_RESET_CLR_NEEDS_EN: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    $fell(flags_reg[BIT_RESET_SEEN]) |-> $past(drv_en) && $past(bus.wr))
    else $error("reset flag cleared without enable");

  AST_RESET_KEPT_EN_LOW: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    bus.wr && bus.addr == ADDR_GLOBAL_STATUS && !drv_en && flags_reg[BIT_RESET_SEEN]
    |=> flags_reg[BIT_RESET_SEEN])
    else $error("reset flag cleared with enable low");

  AST_WARN_LATCH: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    otemp_warn && !otemp_shut && !flags_reg[BIT_OTEMP_SHUT]
    |=> flags_reg[BIT_OTEMP_WARN] && !DRV_SHUTDOWN_O)
    else $error("prewarning not latched or caused shutdown");

  AST_SHUT_LATCH: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    $rose(otemp_shut) |=> DRV_SHUTDOWN_O [*2])
    else $error("shutdown not latched");

  AST_SHUT_HOLD_HOT: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    $fell(flags_reg[BIT_OTEMP_SHUT]) |-> !$past(otemp_shut))
    else $error("shutdown cleared while hot");

  AST_HOT_CLEAR_IGNORED: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    bus.wr && bus.addr == ADDR_GLOBAL_STATUS && otemp_shut && flags_reg[BIT_OTEMP_SHUT]
    |=> flags_reg[BIT_OTEMP_SHUT])
    else $error("shutdown clear accepted while hot");

  AST_STATUS_PIN: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    otemp_shut |=> STATUS_O)
    else $error("status pin not asserted");

endmodule

// ===== rtl/gdrv_status_pkg.sv
/*
  Shared constants for the gate driver global status flag block:
  serial frame layout, register address, flag positions and reset value.
  Assumes nothing of its surroundings; imported by every design file.
*/
package gdrv_status_pkg;

  // ==========================================================
  // Serial frame layout
  localparam int FRAME_BITS = 40;           // Write bit, address, data
  localparam int ADDR_BITS = 7;             // Register address width
  localparam int DATA_BITS = 32;            // Register data width
  localparam int HEAD_BITS = 8;             // Write bit plus address
  localparam int CNT_BITS = 6;              // Bit counter width

  // ==========================================================
  // Register map
  localparam logic [6:0] ADDR_GLOBAL_STATUS = 7'h01;
  localparam int FLAG_WIDTH = 15;           // Register width in bits

  // ==========================================================
  // Flag positions
  localparam int BIT_RESET_SEEN = 0;        // Device has been reset
  localparam int BIT_OTEMP_WARN = 1;        // Overtemperature prewarning
  localparam int BIT_OTEMP_SHUT = 2;        // Overtemperature shutdown

  // Reset value: only the reset-seen flag is up after any reset
  localparam logic [14:0] FLAGS_RESET = 15'h0001;

  // Frame shifter states
  typedef enum logic [0:0] {SPI_IDLE, SPI_SHIFT} spi_state_e;

endpackage

// ===== rtl/gdrv_reg_if.sv
/*
  Register access carrier between the serial slave and the flag bank.
  Assumes both ends run on the same device clock.
*/
`timescale 1ns/1ps
interface gdrv_reg_if;
  import gdrv_status_pkg::*;
  logic [ADDR_BITS-1:0] addr;               // Register address of frame
  logic wr;                                 // One-cycle write strobe
  logic [DATA_BITS-1:0] wdata;              // Write data
  logic [DATA_BITS-1:0] rdata;              // Read data for addr

  // Serial slave drives requests, flag bank answers
  modport ctrl (output addr, output wr, output wdata, input rdata);
  modport regs (input addr, input wr, input wdata, output rdata);
endinterface

// ===== rtl/gdrv_spi_slave.sv
/*
  Serial control slave, oversampled on the device clock.
  Frame: 40 bits MSB first, bit 39 write, bits 38:32 address, 31:0 data.
  Read data of the addressed register shifts out in the same frame.
  Assumes the serial clock runs well below a quarter of MCLK.
*/
`timescale 1ns/1ps
module gdrv_spi_slave
  import gdrv_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial pins, raw
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  // Register side
  gdrv_reg_if.ctrl bus
);
  import gdrv_status_pkg::*;

  // ==========================================================
  // Pin synchronisers: stage one is read only by stage two
  logic [2:0] meta_reg;                     // First stage
  logic [2:0] sync_reg;                     // Second stage: sck, cs_n, sdi
  logic sck_q_reg;                          // Delayed sck for edges

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= 3'h2;
      sync_reg <= 3'h2;
      sck_q_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= {sdi_i, cs_n_i, sck_i};
      sync_reg <= meta_reg;
      sck_q_reg <= sync_reg[0];
    end
  end

  wire sck_rise = sync_reg[0] & ~sck_q_reg;
  wire sck_fall = ~sync_reg[0] & sck_q_reg;
  wire cs_act = ~sync_reg[1];

  // ==========================================================
  // Frame state
  spi_state_e state_reg, state_next;
  logic [CNT_BITS-1:0] cnt_reg, cnt_next;   // Bits received
  logic [FRAME_BITS-1:0] rx_reg, rx_next;   // Incoming shifter
  logic [DATA_BITS-1:0] tx_reg, tx_next;    // Outgoing shifter
  logic [ADDR_BITS-1:0] addr_reg, addr_next;
  logic sdo_reg, sdo_next;
  logic wr_reg, wr_next;
  logic [DATA_BITS-1:0] wdata_reg, wdata_next;

  // Next-state logic for the whole frame
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    sdo_next = sdo_reg;
    wr_next = 1'b0;
    wdata_next = wdata_reg;
    unique case (state_reg)
      SPI_IDLE:
      begin
        // Frame starts when chip select falls
        if (cs_act)
        begin
          state_next = SPI_SHIFT;
          cnt_next = '0;
          sdo_next = 1'b0;
        end
      end
      SPI_SHIFT:
      begin
        if (!cs_act)
        begin
          // Only a complete write frame commits; short frames are dropped
          state_next = SPI_IDLE;
          if (cnt_reg == CNT_BITS'(FRAME_BITS) && rx_reg[FRAME_BITS-1])
          begin
            wr_next = 1'b1;
            wdata_next = rx_reg[DATA_BITS-1:0];
          end
        end
        else if (sck_rise && cnt_reg != CNT_BITS'(FRAME_BITS))
        begin
          rx_next = {rx_reg[FRAME_BITS-2:0], sync_reg[2]};
          cnt_next = cnt_reg + 1'b1;
          // Header complete: latch address and fetch its contents
          if (cnt_reg == CNT_BITS'(HEAD_BITS - 1))
            addr_next = {rx_reg[ADDR_BITS-2:0], sync_reg[2]};
        end
        else if (sck_fall)
        begin
          // Data phase shifts the read word out, MSB first
          if (cnt_reg == CNT_BITS'(HEAD_BITS))
          begin
            sdo_next = bus.rdata[DATA_BITS-1];
            tx_next = {bus.rdata[DATA_BITS-2:0], 1'b0};
          end
          else if (cnt_reg > CNT_BITS'(HEAD_BITS))
          begin
            sdo_next = tx_reg[DATA_BITS-1];
            tx_next = {tx_reg[DATA_BITS-2:0], 1'b0};
          end
        end
      end
    endcase
  end

  // Frame registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SPI_IDLE;
      cnt_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
      addr_reg <= '0;
      sdo_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      sdo_reg <= sdo_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Outputs
  assign sdo_o = sdo_reg;
  assign sdo_oe_n_o = (state_reg == SPI_SHIFT) ? 1'b0 : 1'b1;
  assign bus.addr = addr_reg;
  assign bus.wr = wr_reg;
  assign bus.wdata = wdata_reg;

  // Register access goes through the serial frame only
  AST_WRITE_NEEDS_FULL_FRAME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(wr_reg) |-> $past(cnt_reg) == CNT_BITS'(FRAME_BITS) && $past(state_reg) == SPI_SHIFT)
    else $error("write strobe without full frame");

endmodule

// ===== sim/gdrv_host_model.sv
/*
  Host controller model for the serial control link of the status flag block.
  Assumes the device clock is shared and that the bench calls frame() to move
  one whole 40-bit frame; every pin change happens on a falling device clock.
*/
`timescale 1ns/1ps
module gdrv_host_model
(
  // Device clock
  input wire logic clk_i,
  // Serial pins toward the device
  output logic sck_o,
  output logic csn_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  import gdrv_status_pkg::*;

  // ==========================================================
  // Idle levels
  // Serial clock stands low between frames; select is released
  initial
  begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Data line keeps toggling while deselected, so stale data never looks valid
  always @(negedge clk_i)
  begin
    if (csn_o)
      sdi_o <= ~sdi_o;
  end

  // ==========================================================
  // Frame engine
  // Half serial period of 5 device clocks, above the 3-clock sync limit
  task automatic half();
    repeat (5) @(negedge clk_i);
  endtask

  // One frame, MSB first; read data sampled just before each rising edge
  task automatic frame(input logic wr, input logic [ADDR_BITS-1:0] addr,
                       input logic [DATA_BITS-1:0] wdata,
                       output logic [DATA_BITS-1:0] rdata);
    logic [FRAME_BITS-1:0] word;
    word = {wr, addr, wdata};
    rdata = '0;
    @(negedge clk_i);
    csn_o = 1'b0;
    half();
    for (int k = 0; k < FRAME_BITS; k++)
    begin
      sdi_o = word[FRAME_BITS-1-k];
      half();
      // Data phase only: header time carries no read data
      if (k >= HEAD_BITS)
        rdata[FRAME_BITS-1-k] = sdo_i;
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
    end
    half();
    csn_o = 1'b1;
    half();
  endtask
endmodule

// ===== sim/gate_driver_global_status_flags_tb_top.sv
/*
  Self-checking bench for the global status flag block with its serial slave.
  Assumes the host model file is compiled first; seeded random clears mixed
  with hand-made corner cases.
*/
`timescale 1ns/1ps
module gate_driver_global_status_flags_tb_top;
  import gdrv_status_pkg::*;

  // ==========================================================
  // Signals
  logic mclk, rstn, sck, csn, sdi, sdo, sdo_oen; // Clock, reset, serial pins
  logic drv_en, warn, shut; // Enable pin and comparators
  logic status, shutdn; // Status pin and driver shutdown
  logic [FLAG_WIDTH-1:0] flags; // Flag register view
  logic [FLAG_WIDTH-1:0] model; // Expected flag contents
  logic [DATA_BITS-1:0] rd; // Last read data
  logic [DATA_BITS-1:0] w; // Random clear pattern
  logic pw, ps; // Random comparator pulses
  wire sdo_line = sdo_oen ? 1'b1 : sdo; // Serial data line, pulled up while released
  int n_mismatch;
  int n_tests;

  // ==========================================================
  // Clock, device and host
  always #12.5 mclk = ~mclk;

  gdrv_status_flags u_dut (.MCLK_I(mclk), .RSTN_I(rstn), .SCK_I(sck), .CSN_I(csn),
    .SDI_I(sdi), .SDO_O(sdo), .SDO_OEN_O(sdo_oen), .DRV_EN_I(drv_en),
    .OTEMP_WARN_I(warn), .OTEMP_SHUT_I(shut), .STATUS_O(status),
    .DRV_SHUTDOWN_O(shutdn), .FLAGS_O(flags));

  gdrv_host_model u_host (.clk_i(mclk), .sck_o(sck), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo_line));

  // ==========================================================
  // Checking helpers
  task automatic check(input logic [DATA_BITS-1:0] seen, input logic [DATA_BITS-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bounded wait for the flags to settle, then compare
  task automatic wait_flags(input logic [FLAG_WIDTH-1:0] exp);
    for (int i = 0; i < 20 && flags !== exp; i++)
      @(negedge mclk);
    check({17'h0, flags}, {17'h0, exp});
  endtask

  // Expected flags after a write-one clear
  function automatic logic [FLAG_WIDTH-1:0] clr_exp(input logic [FLAG_WIDTH-1:0] f,
    input logic [DATA_BITS-1:0] wd, input logic en, input logic hot);
    logic [FLAG_WIDTH-1:0] r;
    r = f & ~wd[FLAG_WIDTH-1:0] & 15'h0007;
    if (!en)
      r[0] = f[0];
    if (hot)
      r[2] = f[2];
    return r;
  endfunction

  // Comparator pulse long enough to cross the input synchronisers
  task automatic pulse(input logic pw, input logic ps);
    warn = pw;
    shut = ps;
    repeat (6) @(negedge mclk);
    warn = 1'b0;
    shut = 1'b0;
  endtask

  // ==========================================================
  // Watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (60000) @(negedge mclk);
    n_mismatch++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    drv_en = 1'b1;
    warn = 1'b0;
    shut = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(15));
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);

    // Reset value, pin levels and readback over the serial link
    check({17'h0, flags}, 32'h0000_0001);
    check({31'h0, status}, 32'h0000_0000);
    check({31'h0, sdo_oen}, 32'h0000_0001);
    u_host.frame(1'b0, ADDR_GLOBAL_STATUS, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001);
    $display("test reset done");

    // Prewarning latches while the comparator is high and holds after it drops, no shutdown
    pulse(1'b1, 1'b0);
    wait_flags(15'h0003);
    check({31'h0, shutdn}, 32'h0000_0000);
    $display("test prewarning done");

    // Shutdown latches, drives status pin, refuses clear while hot
    shut = 1'b1;
    wait_flags(15'h0007);
    check({31'h0, status}, 32'h0000_0001);
    check({31'h0, shutdn}, 32'h0000_0001);
    u_host.frame(1'b1, ADDR_GLOBAL_STATUS, 32'h0000_0004, rd);
    repeat (12) @(negedge mclk);
    check({17'h0, flags}, 32'h0000_0007);
    shut = 1'b0;
    u_host.frame(1'b1, ADDR_GLOBAL_STATUS, 32'h0000_0004, rd);
    wait_flags(15'h0003);
    check({31'h0, status}, 32'h0000_0000);
    $display("test shutdown done");

    // Random write-one clears over random flag states
    model = 15'h0003;
    for (int n = 0; n < 5; n++)
    begin
      pw = 1'($urandom);
      ps = 1'($urandom);
      pulse(pw, ps);
      model = model | {12'h000, ps, pw, 1'b0};
      w = $urandom;
      // Comparators are idle now, so only the pulsed bits can be set
      wait_flags(model);
      u_host.frame(1'b1, ADDR_GLOBAL_STATUS, w, rd);
      model = clr_exp(model, w, 1'b1, 1'b0);
      wait_flags(model);
      u_host.frame(1'b0, ADDR_GLOBAL_STATUS, 32'h0000_0000, rd);
      check(rd, {17'h0, model});
    end
    $display("test random clear done");

    // Second reset, then enable-pin gating and enable cycle
    @(negedge mclk);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    check({17'h0, flags}, 32'h0000_0001);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    pulse(1'b1, 1'b1);
    wait_flags(15'h0007);
    drv_en = 1'b0;
    repeat (6) @(negedge mclk);
    u_host.frame(1'b1, ADDR_GLOBAL_STATUS, 32'h0000_0001, rd);
    repeat (12) @(negedge mclk);
    check({17'h0, flags}, 32'h0000_0007);
    drv_en = 1'b1;
    wait_flags(15'h0003);
    // Enable held high by the host while it clears the reset flag
    u_host.frame(1'b1, ADDR_GLOBAL_STATUS, 32'h0000_0001, rd);
    wait_flags(15'h0002);
    $display("test enable done");

    // Unmapped address: write ignored, read gives zero
    u_host.frame(1'b1, 7'h02, 32'h0000_7FFF, rd);
    repeat (12) @(negedge mclk);
    check({17'h0, flags}, 32'h0000_0002);
    u_host.frame(1'b0, 7'h02, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    u_host.frame(1'b0, ADDR_GLOBAL_STATUS, 32'h0000_0000, rd);
    check(rd, 32'h0000_0002);
    $display("test unmapped done");
    test_done();
  end
endmodule
